// ==== bench/pcgpd_top_tb.sv ====
`timescale 1ns/100ps
`include "pcgpd_defs.svh"
module pcgpd_top_tb;
import pcgpd_pkg::*;
localparam int CONV = 5;
localparam int REFC = 10;
logic mclk;
logic rst;
pcgpd_av_req_t av_req;
pcgpd_av_rsp_t av_rsp;
pcgpd_straps_t straps;
logic sleeping;
logic mult_locked_raw;
logic [7:0] pin_in;
logic [5:0] module_clk;
logic mult_select, mult_on, converter_on, main_clk_keep, brownout_on, watchdog_run;
logic ref_on, ref_ready, debug_enabled, usb_card_allowed, iso_card_allowed;
logic [7:0] clock_prescaler;
logic [7:0] pin_in_en;
logic [31:0] rd;
int fail_count;
int compares;
pcgpd_top #(.CONV_OFF_CYC(CONV), .REF_UP_CYC(REFC), .PINS(8)) uut (
    .mclk(mclk), .rst(rst), .av_req(av_req), .av_rsp(av_rsp), .straps(straps),
    .sleeping(sleeping), .mult_locked_raw(mult_locked_raw), .pin_in(pin_in),
    .module_clk(module_clk), .mult_select(mult_select), .mult_on(mult_on),
    .converter_on(converter_on), .clock_prescaler(clock_prescaler),
    .main_clk_keep(main_clk_keep), .brownout_on(brownout_on), .watchdog_run(watchdog_run),
    .ref_on(ref_on), .ref_ready(ref_ready), .debug_enabled(debug_enabled),
    .pin_in_en(pin_in_en), .usb_card_allowed(usb_card_allowed),
    .iso_card_allowed(iso_card_allowed)
);
initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
end
task stop_test;
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
        $display("ALL TESTS PASSED");
    end else begin
        $display("TESTS FAILED");
    end
    $finish;
endtask
task chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
        fail_count++;
        $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
endtask
// one avalon access, holds until waitrequest sampled low
task bus(input logic wr, input logic [4:0] addr, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge mclk);
    av_req.address <= addr;
    av_req.read <= !wr;
    av_req.write <= wr;
    av_req.writedata <= wd;
    do begin
        @(posedge mclk);
        n++;
    end while (av_rsp.waitrequest !== 1'b0 && n < 20);
    if (n >= 20) begin
        fail_count++;
        stop_test();
    end
    rd = av_rsp.readdata;
    av_req.read <= 1'b0;
    av_req.write <= 1'b0;
endtask
task rdchk(input logic [4:0] addr, input logic [31:0] exp);
    bus(1'b0, addr, 32'h0);
    chk(rd, exp);
endtask
task settle;
    @(posedge mclk);
    #1;
endtask
task t_gate;
    rdchk(`PCGPD_OFS_GATE, 32'h0);
    settle();
    chk(module_clk, 6'h3F);
    for (int i = 0; i < 6; i++) begin
        bus(1'b1, `PCGPD_OFS_GATE, 32'hC0 | (32'h1 << i));
        repeat (2) @(posedge mclk);
        settle();
        chk(module_clk, 6'h3F & ~(6'h01 << i));
        chk(usb_card_allowed, i != 0);
        chk(iso_card_allowed, i != 3);
        rdchk(`PCGPD_OFS_GATE, 32'h1 << i);
    end
    bus(1'b1, `PCGPD_OFS_GATE, 32'hFF);
    repeat (2) @(posedge mclk);
    settle();
    chk(module_clk, 6'h00);
    bus(1'b1, `PCGPD_OFS_GATE, 32'h0);
    repeat (2) @(posedge mclk);
    settle();
    chk(module_clk, 6'h3F);
    $display("gate test done");
endtask
task t_power;
    int n;
    bus(1'b1, `PCGPD_OFS_MULT, 32'h3);
    bus(1'b1, `PCGPD_OFS_CONV, 32'h1);
    mult_locked_raw <= 1'b1;
    sleeping <= 1'b1;
    repeat (6) @(posedge mclk);
    #1;
    chk({mult_select, mult_on, converter_on}, 3'b111);
    rdchk(`PCGPD_OFS_MULT, 32'h7);
    bus(1'b1, `PCGPD_OFS_MULT, 32'h2);
    settle();
    chk({mult_select, mult_on}, 2'b01);
    bus(1'b1, `PCGPD_OFS_MULT, 32'h0);
    mult_locked_raw <= 1'b0;
    n = 0;
    do begin
        bus(1'b0, `PCGPD_OFS_MULT, 32'h0);
        n++;
    end while (rd[2] !== 1'b0 && n < 10);
    chk(rd, 32'h0);
    bus(1'b1, `PCGPD_OFS_CONV, 32'h0);
    #1;
    chk(converter_on, 1'b1);
    n = 0;
    while (converter_on !== 1'b0 && n < 50) begin
        settle();
        n++;
    end
    chk(n >= CONV && n <= CONV + 2, 1'b1);
    rdchk(`PCGPD_OFS_CONV, 32'h0);
    bus(1'b1, `PCGPD_OFS_PRESC, 32'h5A);
    rdchk(`PCGPD_OFS_PRESC, 32'h5A);
    bus(1'b1, `PCGPD_OFS_PRESC, 32'h0);
    settle();
    chk(clock_prescaler, 8'h00);
    @(posedge mclk);
    sleeping <= 1'b0;
    bus(1'b1, `PCGPD_OFS_MULT, 32'h3);
    bus(1'b1, `PCGPD_OFS_CONV, 32'h1);
    settle();
    chk({mult_select, mult_on, converter_on}, 3'b111);
    $display("power test done");
endtask
task t_straps;
    for (int k = 0; k < 64; k++) begin
        @(posedge mclk);
        straps <= pcgpd_straps_t'(k[4:0]);
        sleeping <= k[5];
        settle();
        chk(brownout_on, k[4]);
        chk(watchdog_run, k[1]);
        chk(debug_enabled, k[3] & k[2]);
        chk(main_clk_keep, !k[5] | (k[3] & k[2]));
        chk(ref_on, k[4] | k[0]);
    end
    bus(1'b1, `PCGPD_OFS_CORE, 32'h1);
    settle();
    chk({debug_enabled, main_clk_keep}, 2'b00);
    bus(1'b1, `PCGPD_OFS_CORE, 32'h0);
    bus(1'b1, `PCGPD_OFS_WAKE, 32'hA5);
    settle();
    chk(pin_in_en, 8'hA5);
    @(posedge mclk);
    sleeping <= 1'b0;
    settle();
    chk(pin_in_en, 8'hFF);
    $display("strap test done");
endtask
task t_ref;
    int n;
    @(posedge mclk);
    straps <= '0;
    repeat (3) @(posedge mclk);
    #1;
    chk({ref_on, ref_ready}, 2'b00);
    @(posedge mclk);
    straps.monitor_on <= 1'b1;
    n = 0;
    do begin
        settle();
        n++;
    end while (ref_ready !== 1'b1 && n < 40);
    chk(n >= REFC, 1'b1);
    chk(n < 40, 1'b1);
    $display("reference test done");
endtask
task t_unmapped;
    bus(1'b1, `PCGPD_OFS_GATE, 32'h11);
    bus(1'b1, 5'h1C, 32'hFF);
    rdchk(5'h1C, 32'h0);
    rdchk(`PCGPD_OFS_GATE, 32'h11);
    $display("unmapped test done");
endtask
initial begin
    fail_count = 0;
    compares = 0;
    rst = 1'b1;
    av_req = '0;
    straps = '0;
    sleeping = 1'b0;
    mult_locked_raw = 1'b0;
    pin_in = 8'h00;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    rdchk(`PCGPD_OFS_MULT, 32'h0);
    rdchk(`PCGPD_OFS_CONV, 32'h0);
    rdchk(`PCGPD_OFS_PRESC, 32'h0);
    t_gate();
    t_power();
    t_straps();
    t_ref();
    t_unmapped();
    stop_test();
end
endmodule

// ==== design/pcgpd_clock_gate.sv ====
`timescale 1ns/100ps
// glitch-free gate: enable latched while clock is low
module pcgpd_clock_gate (
    input wire logic clk_in,
    input wire logic gate_off,
    output logic clk_out
);
    logic en_l;

    always_latch begin
        if (!clk_in) begin
            en_l = !gate_off;
        end
    end

    assign clk_out = clk_in & en_l;
endmodule

// ==== design/pcgpd_defs.svh ====
`ifndef PCGPD_DEFS_SVH
`define PCGPD_DEFS_SVH

// register byte addresses (word aligned)
`define PCGPD_OFS_GATE 4'h0
`define PCGPD_OFS_MULT 4'h4
`define PCGPD_OFS_CONV 4'h8
`define PCGPD_OFS_PRESC 4'hC
`define PCGPD_OFS_CORE 5'h10
`define PCGPD_OFS_SLEEP 5'h14
`define PCGPD_OFS_WAKE 5'h18

// peripheral_clock_gate_1 fields
`define PCGPD_GATE_W 6
`define PCGPD_GATE_RST 6'h00
`define PCGPD_BIT_KEYPAD 5
`define PCGPD_BIT_CIPHER 4
`define PCGPD_BIT_CARD 3
`define PCGPD_BIT_FAST 2
`define PCGPD_BIT_USBF 1
`define PCGPD_BIT_USBH 0

// multiplier_control fields
`define PCGPD_BIT_MSEL 0
`define PCGPD_BIT_MON 1
`define PCGPD_BIT_MLOCK 2
// converter_control fields
`define PCGPD_BIT_CEN 0
`define PCGPD_BIT_CRDY 1
// core_control field
`define PCGPD_BIT_TPD 0

`define PCGPD_PRESC_RST 8'h00

// converter deactivation sequence, ns
`define PCGPD_CONV_OFF_NS 1000
`define PCGPD_CLK_NS 5
`define PCGPD_CONV_OFF_CYC ((`PCGPD_CONV_OFF_NS + `PCGPD_CLK_NS - 1) / `PCGPD_CLK_NS)
// reference start-up, ns
`define PCGPD_REF_UP_NS 70000
`define PCGPD_REF_UP_CYC ((`PCGPD_REF_UP_NS + `PCGPD_CLK_NS - 1) / `PCGPD_CLK_NS)

`endif

// ==== design/pcgpd_pkg.sv ====
package pcgpd_pkg;
    typedef struct packed {
        logic [4:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
    } pcgpd_av_req_t;

    typedef struct packed {
        logic [31:0] readdata;
        logic waitrequest;
    } pcgpd_av_rsp_t;

    typedef struct packed {
        logic brownout_fuse;
        logic debug_fuse;
        logic test_port_fuse;
        logic watchdog_on;
        logic monitor_on;
    } pcgpd_straps_t;

    typedef enum logic [1:0] {
        PCGPD_CONV_OFF = 2'b00,
        PCGPD_CONV_ON = 2'b01,
        PCGPD_CONV_STOP = 2'b10
    } pcgpd_conv_st_t;
endpackage

// ==== design/pcgpd_timer.sv ====
`timescale 1ns/100ps
// counts up while run is high, done once count reached
module pcgpd_timer #(
    parameter int COUNT = 200
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic run,
    output logic done
);
    localparam int CW = $clog2(COUNT + 1);
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;

    if (COUNT < 1) begin : g_bad_count
        $error("timer count must be at least one");
    end

    assign cnt_d = !run ? '0 : (cnt_q == CW'(COUNT) ? cnt_q : cnt_q + 1'b1);
    assign done = run && (cnt_q == CW'(COUNT));

    always_ff @(posedge mclk) begin
        if (rst) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end
endmodule

// ==== design/pcgpd_top.sv ====
`timescale 1ns/100ps
`include "pcgpd_defs.svh"
// Function
// - keypad gate bit stops keypad clock
// - cipher gate bit stops cipher clock
// - card gate bit stops card clock
// - fast serial gate bit stops its clock
// - usb function gate bit stops its clock
// - usb host gate bit stops its clock
// - host gated blocks usb cards only
// - sleep never changes multiplier or converter
// - select external, stop multiplier, await unlock
// - converter disable runs sequence, then clears ready
// - fused brown-out stays on in sleep
// - reference on only when needed, startup
// - enabled watchdog runs through sleep
// - enabled debug keeps main clock in sleep
// - debug off by either fuse or disable
// - wake pins keep input logic in sleep
// - two upper gate bits read zero
module pcgpd_top #(
    parameter int CONV_OFF_CYC = `PCGPD_CONV_OFF_CYC,
    parameter int REF_UP_CYC = `PCGPD_REF_UP_CYC,
    parameter int PINS = 8
) (
    input wire logic mclk,
    input wire logic rst,
    input pcgpd_pkg::pcgpd_av_req_t av_req,
    output pcgpd_pkg::pcgpd_av_rsp_t av_rsp,
    input pcgpd_pkg::pcgpd_straps_t straps,
    input wire logic sleeping,
    input wire logic mult_locked_raw,
    input wire logic [PINS-1:0] pin_in,
    output logic [5:0] module_clk,
    output logic mult_select,
    output logic mult_on,
    output logic converter_on,
    output logic [7:0] clock_prescaler,
    output logic main_clk_keep,
    output logic brownout_on,
    output logic watchdog_run,
    output logic ref_on,
    output logic ref_ready,
    output logic debug_enabled,
    output logic [PINS-1:0] pin_in_en,
    output logic usb_card_allowed,
    output logic iso_card_allowed
);
    import pcgpd_pkg::*;

    if (PINS < 1 || PINS > 32) begin : g_bad_pins
        $error("PINS must be 1..32");
    end
    if (CONV_OFF_CYC < 1 || REF_UP_CYC < 1) begin : g_bad_timing
        $error("timing counts must be at least one");
    end

    logic [`PCGPD_GATE_W-1:0] gate_q;
    logic msel_q;
    logic mon_q;
    logic cen_q;
    logic [7:0] presc_q;
    logic tpd_q;
    logic [PINS-1:0] wake_q;
    logic [31:0] rdata_q;
    logic ack_q;
    pcgpd_conv_st_t conv_q;
    pcgpd_conv_st_t conv_d;

    wire sel_gate = av_req.address == 5'(`PCGPD_OFS_GATE);
    wire sel_mult = av_req.address == 5'(`PCGPD_OFS_MULT);
    wire sel_conv = av_req.address == 5'(`PCGPD_OFS_CONV);
    wire sel_presc = av_req.address == 5'(`PCGPD_OFS_PRESC);
    wire sel_core = av_req.address == `PCGPD_OFS_CORE;
    wire sel_wake = av_req.address == `PCGPD_OFS_WAKE;
    wire sel_sleep = av_req.address == `PCGPD_OFS_SLEEP;
    // one wait state per access
    wire wr_go = av_req.write && !ack_q;
    wire rd_go = av_req.read && !ack_q;
    // per-register write strobes
    wire wr_gate = wr_go && sel_gate;
    wire wr_mult = wr_go && sel_mult;
    wire wr_conv = wr_go && sel_conv;
    wire wr_presc = wr_go && sel_presc;
    wire wr_core = wr_go && sel_core;
    wire wr_wake = wr_go && sel_wake;
    wire conv_done;
    wire conv_ready = conv_q != PCGPD_CONV_OFF;
    // lock is raw lock gated by multiplier power
    wire lock = mon_q && mult_locked_raw;

    logic [31:0] rdata_d;
    always_comb begin
        rdata_d = 32'h0;
        unique case (1'b1)
            sel_gate: rdata_d = {26'h0, gate_q};
            sel_mult: rdata_d = {29'h0, lock, mon_q, msel_q};
            sel_conv: rdata_d = {30'h0, conv_ready, cen_q};
            sel_presc: rdata_d = {24'h0, presc_q};
            sel_core: rdata_d = {31'h0, tpd_q};
            sel_wake: rdata_d = 32'(wake_q);
            sel_sleep: rdata_d = {31'h0, sleeping};
            default: rdata_d = 32'h0;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            ack_q <= 1'b0;
            rdata_q <= 32'h0;
        end else begin
            ack_q <= (av_req.read || av_req.write) && !ack_q;
            rdata_q <= rd_go ? rdata_d : rdata_q;
        end
    end
    assign av_rsp.waitrequest = (av_req.read || av_req.write) && !ack_q;
    assign av_rsp.readdata = rdata_q;

    // registers change only by bus writes, never by sleep entry
    always_ff @(posedge mclk) begin
        if (rst) begin
            gate_q <= `PCGPD_GATE_RST;
            msel_q <= 1'b0;
            mon_q <= 1'b0;
            cen_q <= 1'b0;
            presc_q <= `PCGPD_PRESC_RST;
            tpd_q <= 1'b0;
            wake_q <= '0;
        end else begin
            if (wr_gate) gate_q <= av_req.writedata[`PCGPD_GATE_W-1:0];
            if (wr_mult) msel_q <= av_req.writedata[`PCGPD_BIT_MSEL];
            if (wr_mult) mon_q <= av_req.writedata[`PCGPD_BIT_MON];
            if (wr_conv) cen_q <= av_req.writedata[`PCGPD_BIT_CEN];
            if (wr_presc) presc_q <= av_req.writedata[7:0];
            if (wr_core) tpd_q <= av_req.writedata[`PCGPD_BIT_TPD];
            if (wr_wake) wake_q <= av_req.writedata[PINS-1:0];
        end
    end

    // converter: enable starts it, disable runs the stop sequence
    always_comb begin
        conv_d = conv_q;
        unique case (conv_q)
            PCGPD_CONV_OFF: if (cen_q) conv_d = PCGPD_CONV_ON;
            PCGPD_CONV_ON: if (!cen_q) conv_d = PCGPD_CONV_STOP;
            PCGPD_CONV_STOP: if (conv_done) conv_d = PCGPD_CONV_OFF;
            default: conv_d = PCGPD_CONV_OFF;
        endcase
    end
    always_ff @(posedge mclk) begin
        if (rst) conv_q <= PCGPD_CONV_OFF;
        else conv_q <= conv_d;
    end

    pcgpd_timer #(.COUNT(CONV_OFF_CYC)) u_conv_tmr (
        .mclk(mclk),
        .rst(rst),
        .run(conv_q == PCGPD_CONV_STOP),
        .done(conv_done)
    );

    // reference start-up after it is powered
    wire ref_need = straps.brownout_fuse || straps.monitor_on;
    wire ref_done;
    pcgpd_timer #(.COUNT(REF_UP_CYC)) u_ref_tmr (
        .mclk(mclk),
        .rst(rst),
        .run(ref_need),
        .done(ref_done)
    );

    // helper counts for the timing assertions
    logic [31:0] stop_cyc_q;
    logic [31:0] ref_cyc_q;
    wire [31:0] stop_cyc_d = (conv_q == PCGPD_CONV_STOP) ? stop_cyc_q + 32'h1 : 32'h0;
    wire [31:0] ref_cyc_d = !ref_need ? 32'h0 :
        ((&ref_cyc_q) ? ref_cyc_q : ref_cyc_q + 32'h1);
    always_ff @(posedge mclk) begin
        if (rst) begin
            stop_cyc_q <= 32'h0;
            ref_cyc_q <= 32'h0;
        end else begin
            stop_cyc_q <= stop_cyc_d;
            ref_cyc_q <= ref_cyc_d;
        end
    end

    genvar g;
    generate
        for (g = 0; g < 6; g++) begin : g_gate
            pcgpd_clock_gate u_cg (
                .clk_in(mclk),
                .gate_off(gate_q[g]),
                .clk_out(module_clk[g])
            );
            // gated clock sampled late in its high phase
            a_gate_clk_off: assert property (
                @(negedge mclk) disable iff (rst)
                gate_q[g] && $past(gate_q[g]) |-> !module_clk[g])
                else $error("module clock runs while gated");
            a_gate_clk_on: assert property (
                @(negedge mclk) disable iff (rst)
                !gate_q[g] && !$past(gate_q[g]) |-> module_clk[g])
                else $error("module clock stopped while enabled");
        end
    endgenerate

    assign mult_select = msel_q;
    assign mult_on = mon_q;
    assign converter_on = conv_ready;
    assign clock_prescaler = presc_q;
    assign usb_card_allowed = !gate_q[`PCGPD_BIT_USBH];
    assign iso_card_allowed = !gate_q[`PCGPD_BIT_CARD];
    assign brownout_on = straps.brownout_fuse;
    assign watchdog_run = straps.watchdog_on;
    assign ref_on = ref_need;
    assign ref_ready = ref_done;
    assign debug_enabled = straps.debug_fuse && straps.test_port_fuse && !tpd_q;
    assign main_clk_keep = !sleeping || debug_enabled;
    assign pin_in_en = sleeping ? wake_q : {PINS{1'b1}};

    a_gate_reads_zero: assert property (@(posedge mclk) disable iff (rst)
        ack_q && $past(av_req.read && sel_gate) |-> av_rsp.readdata[31:6] == 26'h0)
        else $error("reserved gate bits not zero");
    a_gate_write_takes: assert property (@(posedge mclk) disable iff (rst)
        wr_go && sel_gate |=> gate_q == $past(av_req.writedata[5:0]))
        else $error("gate write lost");
    a_sleep_keeps_mult: assert property (@(posedge mclk) disable iff (rst)
        !wr_go |=> mon_q == $past(mon_q) && msel_q == $past(msel_q) && cen_q == $past(cen_q))
        else $error("multiplier or converter moved without write");
    a_lock_drops: assert property (@(posedge mclk) disable iff (rst)
        !mon_q |-> !lock)
        else $error("lock with multiplier off");
    a_conv_ready_hold: assert property (@(posedge mclk) disable iff (rst)
        $fell(conv_ready) |-> $past(stop_cyc_q) >= 32'(CONV_OFF_CYC))
        else $error("ready cleared before sequence");
    a_conv_seq_ends: assert property (@(posedge mclk) disable iff (rst)
        conv_q == PCGPD_CONV_STOP && stop_cyc_q == 32'(CONV_OFF_CYC) |=> !conv_ready)
        else $error("converter sequence overran");
    a_conv_stops: assert property (@(posedge mclk) disable iff (rst)
        conv_q == PCGPD_CONV_ON && !cen_q |=> conv_q == PCGPD_CONV_STOP)
        else $error("converter stop sequence not started");
    a_conv_starts: assert property (@(posedge mclk) disable iff (rst)
        conv_q == PCGPD_CONV_OFF && cen_q |=> conv_ready)
        else $error("converter not started");

    a_ref_wait: assert property (@(posedge mclk) disable iff (rst)
        ref_ready |-> ref_cyc_q >= 32'(REF_UP_CYC))
        else $error("reference ready before start-up");
    a_ref_off: assert property (@(posedge mclk) disable iff (rst)
        !ref_on |-> !ref_ready)
        else $error("reference ready while off");
    a_brownout_kept: assert property (@(posedge mclk) disable iff (rst)
        straps.brownout_fuse |-> brownout_on)
        else $error("brown-out detector dropped");
    a_watchdog_kept: assert property (@(posedge mclk) disable iff (rst)
        straps.watchdog_on |-> watchdog_run)
        else $error("watchdog stopped");
    a_iso_card: assert property (@(posedge mclk) disable iff (rst)
        !gate_q[`PCGPD_BIT_CARD] |-> iso_card_allowed)
        else $error("contact card blocked while clocked");
    a_debug_allowed: assert property (@(posedge mclk) disable iff (rst)
        straps.debug_fuse && straps.test_port_fuse && !tpd_q |-> debug_enabled)
        else $error("debug off without cause");
    a_awake_pins: assert property (@(posedge mclk) disable iff (rst)
        !sleeping |-> pin_in_en == {PINS{1'b1}})
        else $error("pin input disabled while awake");

    a_mult_write: assert property (@(posedge mclk) disable iff (rst)
        wr_mult |=> mult_select == $past(av_req.writedata[`PCGPD_BIT_MSEL])
            && mult_on == $past(av_req.writedata[`PCGPD_BIT_MON]))
        else $error("multiplier write lost");
    a_presc_write: assert property (@(posedge mclk) disable iff (rst)
        wr_presc |=> clock_prescaler == $past(av_req.writedata[7:0]))
        else $error("prescaler write lost");
    a_ack_single: assert property (@(posedge mclk) disable iff (rst)
        ack_q |=> !ack_q)
        else $error("acknowledge longer than one cycle");
    a_rdata_stands: assert property (@(posedge mclk) disable iff (rst)
        !rd_go |=> $stable(av_rsp.readdata))
        else $error("read data moved without read");
    a_sleep_status: assert property (@(posedge mclk) disable iff (rst)
        ack_q && $past(av_req.read && sel_sleep) |-> av_rsp.readdata[0] == $past(sleeping))
        else $error("sleep status wrong");
    a_debug_off: assert property (@(posedge mclk) disable iff (rst)
        tpd_q || !straps.debug_fuse || !straps.test_port_fuse |-> !debug_enabled)
        else $error("debug enabled despite disable");
    a_debug_clock: assert property (@(posedge mclk) disable iff (rst)
        sleeping && debug_enabled |-> main_clk_keep)
        else $error("main clock dropped in debug sleep");
    a_wake_pins: assert property (@(posedge mclk) disable iff (rst)
        sleeping |-> (pin_in_en & wake_q) == wake_q)
        else $error("wake pin input disabled");
    a_usb_card: assert property (@(posedge mclk) disable iff (rst)
        gate_q[0] |-> !usb_card_allowed)
        else $error("usb card allowed while host gated");
    a_one_wait: assert property (@(posedge mclk) disable iff (rst)
        av_req.read && !ack_q |=> !av_rsp.waitrequest)
        else $error("answer late");

    c_conv_stop: cover property (@(posedge mclk) disable iff (rst)
        conv_q == PCGPD_CONV_STOP ##1 conv_q == PCGPD_CONV_OFF);
    c_all_gated: cover property (@(posedge mclk) disable iff (rst) gate_q == 6'h3F);
    c_sleep_debug: cover property (@(posedge mclk) disable iff (rst) sleeping && debug_enabled);
    c_ref_ready: cover property (@(posedge mclk) disable iff (rst) $rose(ref_ready));
    c_host_off_card_on: cover property (@(posedge mclk) disable iff (rst)
        gate_q[`PCGPD_BIT_USBH] && iso_card_allowed);
endmodule
